// ==== dv/tb_usb_uart_defaults_reset_ctrl.sv ====
// Self-checking bench for the defaults and reset controller.
// Assumes a single AHB-Lite master here and the host model on the USB side.
`timescale 1ns/10ps
module tb_usb_uart_defaults_reset_ctrl;
    // ==========================================================
    // Signals
    logic hclk, hresetn, hsel, hwrite;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, class_baud, rd, otp_rate;
    logic hreadyout, hresp, otp_lang_valid, otp_rate_valid, otp_attr_valid, otp_global_lock;
    logic [15:0] otp_lang, otp_attr, string_lang;
    logic [31:0] factory_serial, string_serial, line_baud;
    logic usb_bus_reset, class_set_line, string_req, string_utf16le, string_valid;
    logic [1:0] string_index;
    uudr_pkg::uudr_cfg_t cfg;
    logic low_latency, otp_write_blocked, usb_logic_rst, fifo_flush, reenumerate;
    logic [7:0] line_fmt, usb_attr, usb_maxpwr;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int k;

    uudr_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .otp_lang_valid(otp_lang_valid),
        .otp_lang(otp_lang), .otp_rate_valid(otp_rate_valid), .otp_rate(otp_rate),
        .otp_attr_valid(otp_attr_valid), .otp_attr(otp_attr), .otp_global_lock(otp_global_lock),
        .factory_serial(factory_serial), .usb_bus_reset(usb_bus_reset),
        .class_set_line(class_set_line), .class_baud(class_baud), .string_index(string_index),
        .string_req(string_req), .string_lang(string_lang), .string_serial(string_serial),
        .string_utf16le(string_utf16le), .string_valid(string_valid), .cfg(cfg),
        .low_latency(low_latency), .line_baud(line_baud), .line_fmt(line_fmt),
        .usb_attr(usb_attr), .usb_maxpwr(usb_maxpwr), .otp_write_blocked(otp_write_blocked),
        .usb_logic_rst(usb_logic_rst), .fifo_flush(fifo_flush), .reenumerate(reenumerate));

    uudr_host_model u_host (.hclk(hclk), .usb_bus_reset(usb_bus_reset),
        .class_set_line(class_set_line), .class_baud(class_baud), .string_req(string_req),
        .string_index(string_index));

    // ==========================================================
    // Clock, timeout and tasks
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Whole run needs well under 1000 cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Single word transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= uudr_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
    endtask

    task automatic fetch(input logic [1:0] idx);
        u_host.get_string(idx);
        #1;
        for (k = 0; k < 4 && string_valid !== 1'b1; k++) begin @(posedge hclk); #1; end
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        {otp_lang_valid, otp_rate_valid, otp_attr_valid, otp_lang, otp_rate, otp_attr} = '0;
        otp_global_lock = 1'b1;
        factory_serial = 32'hA5C3_0F1E;
        do_reset();
        chk(cfg, 64'h0000_0000_0000_0000);
        chk(line_baud, uudr_pkg::BAUD_POR);
        chk(line_fmt, uudr_pkg::LINEFMT_POR);
        chk(usb_attr, uudr_pkg::ATTR_BUS);
        chk(usb_maxpwr, uudr_pkg::MAXPWR_100MA);
        chk(otp_write_blocked, 1'b1);
        ahb(1'b0, uudr_pkg::OFS_CTRL, 32'h0000_0000);
        chk(rd[0], 1'b0);
        for (int i = 1; i < 4; i++) begin
            fetch(i[1:0]);
            chk(string_valid, 1'b1);
            chk(string_utf16le, 1'b1);
            chk(string_lang, uudr_pkg::LANG_US);
            if (i == 3) chk(string_serial, factory_serial);
        end
        u_host.set_line(32'd40959);
        #1;
        chk(cfg, {uudr_pkg::FLOW_DEF, uudr_pkg::PINFN_DEF, uudr_pkg::PINDIR_DEF,
            uudr_pkg::EVMASK_DEF});
        chk(low_latency, 1'b1);
        u_host.set_line(32'd40960);
        #1;
        chk(low_latency, 1'b0);
        // Register contents must survive a bus reset
        ahb(1'b1, uudr_pkg::OFS_FLOW, 32'h0000_0002);
        u_host.bus_reset(1'b1);
        repeat (3) @(posedge hclk);
        #1;
        chk({usb_logic_rst, fifo_flush}, 2'b11);
        u_host.bus_reset(1'b0);
        #1;
        for (k = 0; k < 4 && reenumerate !== 1'b1; k++) begin @(posedge hclk); #1; end
        chk(reenumerate, 1'b1);
        chk({usb_logic_rst, fifo_flush}, 2'b00);
        chk(cfg.flow, 16'h0002);
        ahb(1'b0, uudr_pkg::OFS_FLOW, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        ahb(1'b1, uudr_pkg::OFS_CTRL, 32'h0000_0001);
        ahb(1'b1, uudr_pkg::OFS_FLOW, 32'h0000_0004);
        u_host.set_line(32'd1200);
        #1;
        chk(cfg.flow, 16'h0004);
        chk(low_latency, 1'b0);
        ahb(1'b0, 8'hFC, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // Hardware reset with programmed overrides and no lock
        @(posedge hclk);
        {otp_lang_valid, otp_rate_valid, otp_attr_valid, otp_global_lock} <= 4'b1110;
        otp_lang <= 16'h0407;
        otp_rate <= 32'd9600;
        otp_attr <= 16'hC0FA;
        factory_serial <= 32'h3C5A_96E1;
        do_reset();
        chk(cfg, 64'h0000_0000_0000_0000);
        chk(otp_write_blocked, 1'b0);
        chk({usb_attr, usb_maxpwr}, 16'hC0FA);
        ahb(1'b0, uudr_pkg::OFS_CTRL, 32'h0000_0000);
        chk(rd[0], 1'b0);
        ahb(1'b0, uudr_pkg::OFS_OTP, 32'h0000_0000);
        chk(rd, 32'd9600);
        ahb(1'b0, uudr_pkg::OFS_SERIAL, 32'h0000_0000);
        chk(rd, 32'h3C5A_96E1);
        fetch(2'd1);
        chk(string_lang, 16'h0407);
        fetch(2'd3);
        chk(string_lang, uudr_pkg::LANG_US);
        chk(string_serial, 32'h3C5A_96E1);
        u_host.set_line(32'd19200);
        #1;
        chk(low_latency, 1'b0);
        u_host.set_line(32'd4800);
        #1;
        chk(low_latency, 1'b1);
        // Software bus reset through the control register
        ahb(1'b1, uudr_pkg::OFS_CTRL, 32'h0000_0002);
        #1;
        chk({usb_logic_rst, fifo_flush}, 2'b11);
        @(posedge hclk);
        #1;
        chk({reenumerate, usb_logic_rst}, 2'b10);
        chk(cfg.flow, uudr_pkg::FLOW_DEF);
        chk(low_latency, 1'b1);
        end_of_test();
    end
endmodule

// ==== dv/uudr_host_model.sv ====
// USB host side model: class line coding, string fetches and bus reset.
// Assumes the caller runs in step with hclk and calls one task at a time.
`timescale 1ns/10ps
module uudr_host_model (
    // Clock
    input wire logic hclk,
    // Requests toward the bridge
    output logic usb_bus_reset,
    output logic class_set_line,
    output logic [31:0] class_baud,
    output logic string_req,
    output logic [1:0] string_index
);
    // ==========================================================
    // Requests
    initial begin
        usb_bus_reset = 1'b0;
        class_set_line = 1'b0;
        class_baud = 32'h0000_0000;
        string_req = 1'b0;
        string_index = 2'h0;
    end

    // Released lines show the inverse so stale values are never trusted
    task automatic set_line(input logic [31:0] baud);
        @(posedge hclk);
        class_set_line <= 1'b1;
        class_baud <= baud;
        @(posedge hclk);
        class_set_line <= 1'b0;
        class_baud <= ~baud;
    endtask

    task automatic get_string(input logic [1:0] idx);
        @(posedge hclk);
        string_req <= 1'b1;
        string_index <= idx;
        @(posedge hclk);
        string_req <= 1'b0;
        string_index <= ~idx;
    endtask

    task automatic bus_reset(input logic on);
        @(posedge hclk);
        usb_bus_reset <= on;
    endtask
endmodule

// ==== hw/uudr_pkg.sv ====
// Package for the defaults and reset controller of the USB-UART bridge.
// Assumes one 100 MHz clock domain and an AHB-Lite register port.
package uudr_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FLOW = 8'h08;
    localparam logic [7:0] OFS_PINFN = 8'h0C;
    localparam logic [7:0] OFS_PINDIR = 8'h10;
    localparam logic [7:0] OFS_EVMASK = 8'h14;
    localparam logic [7:0] OFS_BAUD = 8'h18;
    localparam logic [7:0] OFS_OTP = 8'h1C;
    localparam logic [7:0] OFS_ATTR = 8'h20;
    localparam logic [7:0] OFS_LANG = 8'h24;
    localparam logic [7:0] OFS_SERIAL = 8'h28;
    localparam logic [7:0] OFS_LINEFMT = 8'h2C;
    // ==========================================================
    // Class-driver defaults
    localparam logic [15:0] FLOW_DEF = 16'h0001;
    localparam logic [15:0] PINFN_DEF = 16'h0339;
    localparam logic [15:0] PINDIR_DEF = 16'h0028;
    localparam logic [15:0] EVMASK_DEF = 16'h03F0;
    localparam logic [31:0] LL_RATE_DEF = 32'h0000_A000; // 40960 bps
    // Power-up line defaults: 115200 bps, 8N1, no flow control
    localparam logic [31:0] BAUD_POR = 32'h0001_C200;
    localparam logic [7:0] LINEFMT_POR = 8'h08;
    localparam logic [15:0] FLOW_POR = 16'h0000;
    localparam logic [15:0] LANG_US = 16'h0409;
    // Bus powered, 100 mA in 2 mA units
    localparam logic [7:0] ATTR_BUS = 8'h80;
    localparam logic [7:0] MAXPWR_100MA = 8'h32;
    // Fields
    localparam int CTRL_VENDOR_BIT = 0;
    localparam int CTRL_BUSRST_BIT = 1;
    localparam int CTRL_LOCK_BIT = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_ENUM = 2'b01,
        ST_RUN = 2'b11
    } uudr_state_t;
    typedef struct packed {
        logic [15:0] flow;
        logic [15:0] pinfn;
        logic [15:0] pindir;
        logic [15:0] evmask;
    } uudr_cfg_t;
endpackage

// ==== hw/uudr_top.sv ====
// Defaults and reset controller: string ids, class defaults, power and reset.
// Assumes AHB-Lite single-word transfers and OTP values on plain inputs.
//
// Function
// (R1) Serve manufacturer, product and serial string descriptor indexes.
// (R2) Strings are encoded UTF-16LE by default.
// (R3) Language id defaults US English, OTP may override for strings; code never applies the override to the serial string (index 3).
// (R4) Serial string comes from stored factory value.
// (R5) Class mode defaults flow select to 0x0001.
// (R6) Class mode defaults pin function to 0x0339.
// (R7) Class mode defaults pin direction to 0x0028.
// (R8) Class mode defaults event mask to 0x03F0.
// (R9) Class mode low-latency rate limit defaults to 40960 bps.
// (R10) Programmed OTP limit overrides built-in rate limit.
// (R11) Vendor driver sets flag bit 0 right after attach.
// (R12) Flag set: class requests load no class defaults.
// (R13) Report bus powered 100 mA unless OTP reprograms.
// (R14) Power-on or hardware reset restores all defaults incl. OTP.
// (R15) Reset with global lock set blocks OTP writes.
// (R16) Bus reset restarts USB logic, flushes FIFOs, re-enumerates.
// (R17) Bus reset keeps registers and pin configuration.
// (R18) Class mode enables low latency when baud below limit.
// (R19) Power-up line is 115200 8N1 no flow control.
// (R20) Vendor flag clears on power-on and hardware reset.
`timescale 1ns/10ps
module uudr_top #(
    parameter int SERIAL_W = 32
) (
    // Clock and reset (power-on and hardware reset combined)
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // OTP settings
    input wire logic otp_lang_valid,
    input wire logic [15:0] otp_lang,
    input wire logic otp_rate_valid,
    input wire logic [31:0] otp_rate,
    input wire logic otp_attr_valid,
    input wire logic [15:0] otp_attr,
    input wire logic otp_global_lock,
    input wire logic [SERIAL_W-1:0] factory_serial,
    // USB side events
    input wire logic usb_bus_reset,
    input wire logic class_set_line,
    input wire logic [31:0] class_baud,
    input wire logic [1:0] string_index,
    input wire logic string_req,
    // Outputs
    output logic [15:0] string_lang,
    output logic [SERIAL_W-1:0] string_serial,
    output logic string_utf16le,
    output logic string_valid,
    output uudr_pkg::uudr_cfg_t cfg,
    output logic low_latency,
    output logic [31:0] line_baud,
    output logic [7:0] line_fmt,
    output logic [7:0] usb_attr,
    output logic [7:0] usb_maxpwr,
    output logic otp_write_blocked,
    output logic usb_logic_rst,
    output logic fifo_flush,
    output logic reenumerate
);
    // Serial readback and string path carry at most one bus word
    if (SERIAL_W < 8 || SERIAL_W > 32) begin : g_bad_serial_w
        $error("SERIAL_W must be 8..32");
    end

    // ==========================================================
    // Bus slave
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic vendor_q;
    logic lock_q;
    uudr_pkg::uudr_state_t state_q;
    logic [31:0] rate_limit;

    wire take = hsel && hready && htrans == uudr_pkg::HTRANS_NONSEQ;
    wire wr = wr_pend_q;

    // Write strobe for one register, valid in the data phase
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_pend_q && wr_addr_q == ofs;
    endfunction

    wire wr_ctrl = wr_hit(uudr_pkg::OFS_CTRL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= take && hwrite;
            wr_addr_q <= take ? haddr : wr_addr_q;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        case (a)
            uudr_pkg::OFS_CTRL: rd_mux = {29'h0, lock_q, 1'b0, vendor_q};
            uudr_pkg::OFS_STATUS: rd_mux = {28'h0, low_latency, otp_write_blocked,
                                            state_q};
            uudr_pkg::OFS_FLOW: rd_mux = {16'h0, cfg.flow};
            uudr_pkg::OFS_PINFN: rd_mux = {16'h0, cfg.pinfn};
            uudr_pkg::OFS_PINDIR: rd_mux = {16'h0, cfg.pindir};
            uudr_pkg::OFS_EVMASK: rd_mux = {16'h0, cfg.evmask};
            uudr_pkg::OFS_BAUD: rd_mux = line_baud;
            uudr_pkg::OFS_OTP: rd_mux = rate_limit;
            uudr_pkg::OFS_ATTR: rd_mux = {16'h0, usb_attr, usb_maxpwr};
            uudr_pkg::OFS_LANG: rd_mux = {16'h0, string_lang};
            uudr_pkg::OFS_SERIAL: rd_mux = 32'(factory_serial);
            uudr_pkg::OFS_LINEFMT: rd_mux = {24'h0, line_fmt};
            default: rd_mux = 32'h0000_0000;
        endcase
    endfunction

    // Read data registered at the end of the address phase, so reads answer with zero wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= rd_mux(haddr);
        end
    end

    // ==========================================================
    // Vendor flag and lock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vendor_q <= 1'b0; // [R20]
        end else if (wr_ctrl) begin
            vendor_q <= hwdata[uudr_pkg::CTRL_VENDOR_BIT]; // [R11]
        end
    end

    // Lock is caught once after reset release, not under the async reset
    logic lock_taken_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= 1'b0;
            lock_taken_q <= 1'b0;
            otp_write_blocked <= 1'b0;
        end else begin
            lock_taken_q <= 1'b1;
            if (!lock_taken_q) begin
                lock_q <= otp_global_lock;
                otp_write_blocked <= otp_global_lock; // [R15]
            end
        end
    end

    // ==========================================================
    // Bus reset sequencing: registers untouched, only USB side restarts
    logic bus_rst_req;
    assign bus_rst_req = usb_bus_reset || (wr_ctrl && hwdata[uudr_pkg::CTRL_BUSRST_BIT]);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= uudr_pkg::ST_RESET;
            usb_logic_rst <= 1'b1;
            fifo_flush <= 1'b1;
            reenumerate <= 1'b0;
        end else begin
            usb_logic_rst <= bus_rst_req; // [R16]
            fifo_flush <= bus_rst_req; // [R16]
            reenumerate <= 1'b0;
            case (state_q)
                uudr_pkg::ST_RESET: begin
                    if (!bus_rst_req) begin
                        state_q <= uudr_pkg::ST_ENUM;
                        reenumerate <= 1'b1; // [R16]
                    end
                end
                uudr_pkg::ST_ENUM: state_q <= bus_rst_req ? uudr_pkg::ST_RESET
                                                          : uudr_pkg::ST_RUN;
                uudr_pkg::ST_RUN: if (bus_rst_req) state_q <= uudr_pkg::ST_RESET;
                default: state_q <= uudr_pkg::ST_RESET;
            endcase
        end
    end

    // ==========================================================
    // Configuration defaults; bus reset does not touch these [R17]
    assign rate_limit = otp_rate_valid ? otp_rate : uudr_pkg::LL_RATE_DEF; // [R9] [R10]
    wire class_load = class_set_line && !vendor_q; // [R12]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= '{flow: uudr_pkg::FLOW_POR, pinfn: 16'h0000,
                     pindir: 16'h0000, evmask: 16'h0000}; // [R14] [R19]
        end else if (class_load) begin
            cfg <= '{flow: uudr_pkg::FLOW_DEF, pinfn: uudr_pkg::PINFN_DEF,
                     pindir: uudr_pkg::PINDIR_DEF,
                     evmask: uudr_pkg::EVMASK_DEF}; // [R5] [R6] [R7] [R8]
        end else if (wr) begin
            case (wr_addr_q)
                uudr_pkg::OFS_FLOW: cfg.flow <= hwdata[15:0];
                uudr_pkg::OFS_PINFN: cfg.pinfn <= hwdata[15:0];
                uudr_pkg::OFS_PINDIR: cfg.pindir <= hwdata[15:0];
                uudr_pkg::OFS_EVMASK: cfg.evmask <= hwdata[15:0];
                default: cfg <= cfg;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_baud <= uudr_pkg::BAUD_POR; // [R19]
            line_fmt <= uudr_pkg::LINEFMT_POR; // [R19]
            low_latency <= 1'b0;
        end else if (class_set_line) begin
            line_baud <= class_baud;
            if (!vendor_q) low_latency <= class_baud < rate_limit; // [R18]
        end else if (wr_hit(uudr_pkg::OFS_BAUD)) begin
            line_baud <= hwdata;
        end else if (wr_hit(uudr_pkg::OFS_LINEFMT)) begin
            line_fmt <= hwdata[7:0];
        end else if (wr_hit(uudr_pkg::OFS_STATUS)) begin
            low_latency <= hwdata[3];
        end
    end

    // ==========================================================
    // Power attributes and strings
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            usb_attr <= uudr_pkg::ATTR_BUS; // [R13]
            usb_maxpwr <= uudr_pkg::MAXPWR_100MA; // [R13]
            string_lang <= uudr_pkg::LANG_US; // [R3]
            string_serial <= '0;
            string_utf16le <= 1'b1; // [R2]
            string_valid <= 1'b0;
        end else begin
            if (otp_attr_valid) begin
                usb_attr <= otp_attr[15:8]; // [R13]
                usb_maxpwr <= otp_attr[7:0];
            end
            string_valid <= string_req && string_index != 2'd0; // [R1]
            string_utf16le <= 1'b1; // [R2]
            string_lang <= (otp_lang_valid && string_index != 2'd3) ? otp_lang
                                                                   : uudr_pkg::LANG_US; // [R3]
            string_serial <= factory_serial; // [R4]
        end
    end

    // ==========================================================
    // Checks
    // A register write in the same cycle may still change the config
    AST_VENDOR_BLOCKS: assert property ( // [R12]
        @(posedge hclk) disable iff (!hresetn)
        vendor_q && class_set_line && !wr |=> $stable(cfg))
        else $error("class defaults loaded while vendor flag set");
    AST_CLASS_LOAD: assert property ( // [R6]
        @(posedge hclk) disable iff (!hresetn)
        class_load |=> cfg.pinfn == uudr_pkg::PINFN_DEF && cfg.flow == uudr_pkg::FLOW_DEF)
        else $error("class defaults not applied");
    AST_LL: assert property ( // [R18]
        @(posedge hclk) disable iff (!hresetn)
        class_load |=> low_latency == ($past(class_baud) < $past(rate_limit)))
        else $error("low latency mismatch");
    AST_FLUSH: assert property ( // [R16]
        @(posedge hclk) disable iff (!hresetn)
        usb_bus_reset |=> fifo_flush && usb_logic_rst)
        else $error("bus reset did not flush");
    AST_KEEP: assert property ( // [R17]
        @(posedge hclk) disable iff (!hresetn)
        usb_bus_reset && !class_set_line && !wr |=> $stable(cfg))
        else $error("bus reset altered configuration");
    // Sampled reset term keeps out the release edge, still a reset cycle inside
    AST_ENUM: assert property ( // [R16]
        @(posedge hclk) disable iff (!hresetn)
        hresetn && state_q == uudr_pkg::ST_RESET && !bus_rst_req |=> reenumerate)
        else $error("no re-enumeration");
    AST_RST_DROP: assert property ( // [R16]
        @(posedge hclk) disable iff (!hresetn)
        hresetn && !bus_rst_req |=> !usb_logic_rst && !fifo_flush)
        else $error("USB side reset held without request");
    AST_LOCK: assert property ( // [R15]
        @(posedge hclk) disable iff (!hresetn)
        $rose(lock_taken_q) |-> otp_write_blocked == $past(otp_global_lock))
        else $error("lock not applied");
    AST_PWR: assert property ( // [R13]
        @(posedge hclk) disable iff (!hresetn)
        !otp_attr_valid |=> $stable({usb_attr, usb_maxpwr}))
        else $error("power attributes changed without OTP");
    AST_STR_VALID: assert property ( // [R1]
        @(posedge hclk) disable iff (!hresetn)
        string_req && string_index != 2'd0 |=> string_valid)
        else $error("string request not answered");
    AST_SERIAL_LANG: assert property ( // [R3]
        @(posedge hclk) disable iff (!hresetn)
        string_req && string_index == 2'd3 |=> string_lang == uudr_pkg::LANG_US)
        else $error("serial string language not US English");
    AST_SERIAL_VAL: assert property ( // [R4]
        @(posedge hclk) disable iff (!hresetn)
        string_req |=> string_serial == $past(factory_serial))
        else $error("serial string differs from stored value");
endmodule
